// File: mrz_pkg.sv
// Shared constants for the mode register zero decode block.
package mrz_pkg;

  // ---------------------------------------------------------------------------
  // Command encoding and address layout
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam int REG_W  = 19;
  localparam int COL_W  = 10;

  // Command codes carried on the command lines (chip select, row, column, write).
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;

  // Bank address that selects mode register zero.
  localparam logic [2:0] BANK_MRZ = 3'h0;

  // ---------------------------------------------------------------------------
  // Field positions of mode register zero
  // ---------------------------------------------------------------------------
  localparam int BL_LSB   = 0;
  localparam int BL_MSB   = 1;
  localparam int BT_BIT   = 3;
  localparam int CL_LSB   = 4;
  localparam int CL_MSB   = 6;
  localparam int CL2_BIT  = 2;
  localparam int DLL_BIT  = 8;
  localparam int WR_LSB   = 9;
  localparam int WR_MSB   = 11;
  localparam int PD_BIT   = 12;
  localparam int OTF_BIT  = 12;
  localparam logic [18:0] RSVD_MASK = 19'h4E080;
  localparam logic [18:0] RESET_VAL = 19'h00000;

  // Burst length field codes.
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_CHOP4  = 2'h2;

  // Write recovery codes for 5, 6, 7, 8, 10 and 12 cycles.
  localparam logic [2:0] WR_5  = 3'h1;
  localparam logic [2:0] WR_6  = 3'h2;
  localparam logic [2:0] WR_7  = 3'h3;
  localparam logic [2:0] WR_8  = 3'h4;
  localparam logic [2:0] WR_10 = 3'h5;
  localparam logic [2:0] WR_12 = 3'h6;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int BEATS        = 8;
  localparam int DLL_LOCK_CYC = 512;
  localparam int MRD_CYC      = 4;
  localparam int MOD_CYC      = 12;
  localparam int CL_MIN       = 5;
  localparam int CL_MAX       = 14;

endpackage : mrz_pkg

// File: mrz_if.sv
// Command and data link between the controller end and the device end.
`timescale 1ns/1ps
interface mrz_if;
  logic [3:0]  cmd;
  logic [2:0]  bank;
  logic [15:0] addr;
  logic        cke;
  logic        dq_oe;
  logic [2:0]  beat_col;
  logic        beat_valid;

  modport device (
    input  cmd,
    input  bank,
    input  addr,
    input  cke,
    output dq_oe,
    output beat_col,
    output beat_valid
  );

  modport ctrl (
    output cmd,
    output bank,
    output addr,
    output cke,
    input  dq_oe,
    input  beat_col,
    input  beat_valid
  );
endinterface : mrz_if

// File: mrz_order.sv
// Column order generator for one beat of a burst.
`timescale 1ns/1ps
module mrz_order (
  input  wire logic [2:0] start_col,
  input  wire logic [2:0] beat,
  input  wire logic       interleave,
  input  wire logic       is_write,
  output logic [2:0]      col
);

  // Reads keep the start nibble then the other; writes ignore low bits.
  always_comb begin
    if (is_write) begin
      col = {start_col[2] ^ beat[2], beat[1:0]};
    end else if (interleave) begin
      col = start_col ^ beat;
    end else begin
      col = {start_col[2] ^ beat[2], 2'(start_col[1:0] + beat[1:0])};
    end
  end

endmodule : mrz_order

// File: mrz_device.sv
// Device end: mode register zero capture and burst column sequencing.
// Notes on behaviour
// - Field 01 picks chop or eight by bit12.
// - Field 00 is eight, 10 is chop.
// - Bursts wrap inside aligned block of burst length.
// - Same burst length for reads and writes.
// - Order bit: 0 sequential, 1 interleaved.
// - Controller writes reserved bits as zero.
// - Sequential chop read: nibble modulo four, then tri-state.
// - Interleaved chop read: start XOR beat, then tri-state.
// - Sequential eight read: nibble, then other nibble.
// - Interleaved eight read: start XOR beat index.
// - Writes ignore low column bits, in order.
// - Chop starts internally when eight would.
// - DLL reset bit starts reset, then self-clears.
// - Controller waits 512 cycles before read after reset.
// - Controller programs write recovery from legal set.
// - Power-down bit 0 stops DLL, slow exit.
// - Power-down bit 1 keeps DLL, fast exit.
// - Read latency from field, 5 to 14.
// - Controller loads only when idle, respecting delays.
`timescale 1ns/1ps
module mrz_device (
  input  wire logic        clock,
  input  wire logic        rst_b,
  mrz_if.device            link,
  input  wire logic        pd_entry,
  output logic [18:0]      mode_reg_zero,
  output logic [3:0]       read_latency_cycles,
  output logic             dll_reset_pulse,
  output logic             dll_running,
  output logic             fixed_eight_beat_burst,
  output logic             burst_active,
  output logic             burst_is_write
);

  typedef enum logic [1:0] {MRZ_IDLE, MRZ_WAIT, MRZ_BURST} mrz_state_e;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [18:0]     next_mode_reg_zero;
  logic            next_dll_reset_pulse;
  logic [3:0]      next_read_latency_cycles;
  mrz_state_e      state;
  mrz_state_e      next_state;
  logic [3:0]      wait_cnt;
  logic [3:0]      next_wait_cnt;
  logic [2:0]      beat;
  logic [2:0]      next_beat;
  logic [2:0]      start_col;
  logic [2:0]      next_start_col;
  logic            chop;
  logic            next_chop;
  logic            next_burst_is_write;
  logic            next_fixed_eight;
  logic            next_dll_running;
  logic [2:0]      col;
  logic            cmd_rw;
  logic            cmd_chop;
  logic [2:0]      cl_code;
  logic            pd_s1;
  logic            pd_s2;

  // ---------------------------------------------------------------------------
  // Mode capture and latency decode
  // ---------------------------------------------------------------------------

  // Decodes the latency code into whole cycles; half-cycle codes do not exist.
  // Code 1 gives five cycles, and the extra bit moves codes 0 to 2 up to 12 to 14.
  always_comb begin
    cl_code = mode_reg_zero[mrz_pkg::CL_MSB:mrz_pkg::CL_LSB];
    next_read_latency_cycles = 4'(int'(cl_code) + mrz_pkg::CL_MIN - 1);
    if (mode_reg_zero[mrz_pkg::CL2_BIT]) begin
      next_read_latency_cycles = 4'(int'(cl_code) + mrz_pkg::CL_MIN + 7);
    end
  end

  // Captures the register on a load to bank zero; the DLL reset bit self-clears.
  // A load that arrives while a burst is in flight is dropped, so the controller waits.
  always_comb begin
    next_mode_reg_zero   = mode_reg_zero;
    next_dll_reset_pulse = 1'b0;
    next_mode_reg_zero[mrz_pkg::DLL_BIT] = 1'b0;
    if (link.cmd == mrz_pkg::CMD_MRS && link.bank == mrz_pkg::BANK_MRZ && state == MRZ_IDLE) begin
      next_mode_reg_zero   = {3'h0, link.addr[15:0] & ~mrz_pkg::RSVD_MASK[15:0]};
      next_dll_reset_pulse = link.addr[mrz_pkg::DLL_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Burst sequencing
  // ---------------------------------------------------------------------------

  // Length selection: chop comes from the field or from bit 12 in on-the-fly mode.
  always_comb begin
    cmd_rw = link.cke && ((link.cmd == mrz_pkg::CMD_READ) || (link.cmd == mrz_pkg::CMD_WRITE));
    case (mode_reg_zero[mrz_pkg::BL_MSB:mrz_pkg::BL_LSB])
      mrz_pkg::BL_FIXED8: cmd_chop = 1'b0;
      mrz_pkg::BL_CHOP4:  cmd_chop = 1'b1;
      mrz_pkg::BL_OTF:    cmd_chop = ~link.addr[mrz_pkg::OTF_BIT];
      default:            cmd_chop = 1'b0;
    endcase
  end

  // Burst sequencer: latency wait, then eight beat slots whether chopped or not.
  always_comb begin
    next_state          = state;
    next_wait_cnt       = wait_cnt;
    next_beat           = beat;
    next_start_col      = start_col;
    next_chop           = chop;
    next_burst_is_write = burst_is_write;
    case (state)
      MRZ_IDLE: begin
        if (cmd_rw) begin
          next_state          = MRZ_WAIT;
          next_wait_cnt       = (link.cmd == mrz_pkg::CMD_READ) ? read_latency_cycles : 4'h1;
          next_beat           = 3'h0;
          next_start_col      = link.addr[2:0];
          // Eight-beat writes always run from column 0; the start bits are ignored.
          if (link.cmd == mrz_pkg::CMD_WRITE && !cmd_chop) begin
            next_start_col = 3'h0;
          end
          next_chop           = cmd_chop;
          next_burst_is_write = (link.cmd == mrz_pkg::CMD_WRITE);
        end
      end
      MRZ_WAIT: begin
        next_wait_cnt = wait_cnt - 4'h1;
        if (wait_cnt <= 4'h1) begin
          next_state = MRZ_BURST;
        end
      end
      MRZ_BURST: begin
        next_beat = beat + 3'h1;
        if (beat == 3'h7) begin
          next_state = MRZ_IDLE;
        end
      end
      default: next_state = MRZ_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Beat outputs
  // ---------------------------------------------------------------------------

  // Column of the current beat inside the aligned block.
  mrz_order u_order (
    .start_col  (start_col),
    .beat       (beat),
    .interleave (mode_reg_zero[mrz_pkg::BT_BIT]),
    .is_write   (burst_is_write),
    .col        (col)
  );

  // Fixed-eight flag is the inverse of the latched chop; the DLL stops in power-down when the power-down bit is 0.
  always_comb begin
    next_fixed_eight = ~chop;
    next_dll_running = ~(pd_s2 && !mode_reg_zero[mrz_pkg::PD_BIT]);
  end

  // Beat slot outputs; a chop leaves its last four slots undriven.
  assign burst_active    = (state == MRZ_BURST);
  assign link.beat_valid = (state == MRZ_BURST) && !(chop && beat[2]);
  assign link.dq_oe      = link.beat_valid && !burst_is_write;
  assign link.beat_col   = col;

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------

  // Registers all state; the power-down request is a pin and is synchronised.
  // Only the second synchroniser stage is read, so a metastable first stage never spreads.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode_reg_zero          <= mrz_pkg::RESET_VAL;
      dll_reset_pulse        <= 1'b0;
      read_latency_cycles    <= 4'(mrz_pkg::CL_MIN);
      state                  <= MRZ_IDLE;
      wait_cnt               <= 4'h0;
      beat                   <= 3'h0;
      start_col              <= 3'h0;
      chop                   <= 1'b0;
      burst_is_write         <= 1'b0;
      fixed_eight_beat_burst <= 1'b1;
      dll_running            <= 1'b1;
      pd_s1                  <= 1'b0;
      pd_s2                  <= 1'b0;
    end else begin
      mode_reg_zero          <= next_mode_reg_zero;
      dll_reset_pulse        <= next_dll_reset_pulse;
      read_latency_cycles    <= next_read_latency_cycles;
      state                  <= next_state;
      wait_cnt               <= next_wait_cnt;
      beat                   <= next_beat;
      start_col              <= next_start_col;
      chop                   <= next_chop;
      burst_is_write         <= next_burst_is_write;
      fixed_eight_beat_burst <= next_fixed_eight;
      dll_running            <= next_dll_running;
      pd_s1                  <= pd_entry;
      pd_s2                  <= pd_s1;
    end
  end

endmodule : mrz_device

// File: mrz_ctrl.sv
// Controller end: issues mode loads, reads and writes with the required waits.
`timescale 1ns/1ps
module mrz_ctrl #(
  parameter int DLL_LOCK = mrz_pkg::DLL_LOCK_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  mrz_if.ctrl              link,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_kind,
  input  wire logic [18:0] req_data,
  output logic             req_ready,
  output logic             dll_locked
);

  // ---------------------------------------------------------------------------
  // Command issue with guard counters
  // ---------------------------------------------------------------------------
  logic [3:0]  cmd_q;
  logic [3:0]  next_cmd;
  logic [2:0]  bank_q;
  logic [2:0]  next_bank;
  logic [15:0] addr_q;
  logic [15:0] next_addr;
  logic [9:0]  lock_cnt;
  logic [9:0]  next_lock_cnt;
  logic [4:0]  guard;
  logic [4:0]  next_guard;
  logic [2:0]  wr_code;

  assign link.cke   = 1'b1;
  assign link.cmd   = cmd_q;
  assign link.bank  = bank_q;
  assign link.addr  = addr_q;
  assign dll_locked = (lock_cnt == 10'h0);
  // Reads wait for DLL lock; every command waits for the previous burst and guard.
  assign req_ready  = (guard == 5'h00) && !link.beat_valid &&
                      (req_kind != 2'h1 || dll_locked);

  // Kind 0 loads the mode register, 1 reads, 2 writes, others are ignored.
  always_comb begin
    next_cmd      = mrz_pkg::CMD_NOP;
    next_bank     = 3'h0;
    next_addr     = 16'h0000;
    next_guard    = (guard != 5'h00) ? guard - 5'h01 : 5'h00;
    next_lock_cnt = (lock_cnt != 10'h0) ? lock_cnt - 10'h1 : 10'h0;
    wr_code       = req_data[mrz_pkg::WR_MSB:mrz_pkg::WR_LSB];
    if (req_valid && req_ready) begin
      case (req_kind)
        2'h0: begin
          next_cmd   = mrz_pkg::CMD_MRS;
          next_bank  = mrz_pkg::BANK_MRZ;
          next_addr  = req_data[15:0] & ~mrz_pkg::RSVD_MASK[15:0];
          if (wr_code == 3'h0 || wr_code == 3'h7) begin
            next_addr[mrz_pkg::WR_MSB:mrz_pkg::WR_LSB] = mrz_pkg::WR_12;
          end
          next_guard = 5'(mrz_pkg::MOD_CYC);
          if (req_data[mrz_pkg::DLL_BIT]) begin
            next_lock_cnt = 10'(DLL_LOCK);
          end
        end
        2'h1: begin
          next_cmd   = mrz_pkg::CMD_READ;
          next_addr  = req_data[15:0];
          // Covers the longest latency and all eight slots, chopped ones included.
          next_guard = 5'(mrz_pkg::CL_MAX + mrz_pkg::BEATS + 1);
        end
        2'h2: begin
          next_cmd   = mrz_pkg::CMD_WRITE;
          next_addr  = req_data[15:0];
          next_guard = 5'(mrz_pkg::BEATS + 2);
        end
        default: next_cmd = mrz_pkg::CMD_NOP;
      endcase
    end
  end

  // Registers command lines and counters.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cmd_q    <= mrz_pkg::CMD_NOP;
      bank_q   <= 3'h0;
      addr_q   <= 16'h0000;
      guard    <= 5'h00;
      lock_cnt <= 10'h0;
    end else begin
      cmd_q    <= next_cmd;
      bank_q   <= next_bank;
      addr_q   <= next_addr;
      guard    <= next_guard;
      lock_cnt <= next_lock_cnt;
    end
  end

endmodule : mrz_ctrl

// File: mrz_asserts.sv
// Checker for the command and beat lines between the two ends.
`timescale 1ns/1ps
module mrz_asserts (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [3:0]  cmd,
  input wire logic [2:0]  bank,
  input wire logic [15:0] addr,
  input wire logic        dq_oe,
  input wire logic [2:0]  beat_col,
  input wire logic        beat_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [3:0] idx, next_idx;
  logic [2:0] first, next_first;
  logic       bt, next_bt, wr, next_wr;
  // Beat index, first column, burst order and direction of the burst in flight.
  always_comb begin
    next_idx   = beat_valid ? idx + 4'h1 : 4'h0;
    next_first = (beat_valid && idx == 4'h0) ? beat_col : first;
    next_bt    = (cmd == mrz_pkg::CMD_MRS && bank == mrz_pkg::BANK_MRZ) ? addr[mrz_pkg::BT_BIT] : bt;
    next_wr    = (cmd == mrz_pkg::CMD_WRITE) ? 1'b1 : (cmd == mrz_pkg::CMD_READ) ? 1'b0 : wr;
  end
  // Registers the tracking state.
  always_ff @(posedge clock) begin
    idx   <= rst_b ? next_idx : 4'h0;
    first <= rst_b ? next_first : 3'h0;
    bt    <= rst_b ? next_bt : 1'b0;
    wr    <= rst_b ? next_wr : 1'b0;
  end
  sequence s_half; beat_valid [*4]; endsequence
  sequence s_quiet; (cmd == mrz_pkg::CMD_NOP) [*8]; endsequence
  a_oe_live: assert property (dq_oe |-> beat_valid && !wr)
    else $error("data driven outside a read beat");
  a_chop_min: assert property ($rose(beat_valid) |-> s_half)
    else $error("burst shorter than four beats");
  a_run_len: assert property (beat_valid |-> idx < 4'h8)
    else $error("burst longer than eight beats");
  a_burst_end: assert property ($fell(beat_valid) |-> idx == 4'h4 || idx == 4'h8)
    else $error("burst of odd length");
  a_nibble_wrap: assert property (beat_valid && idx != 4'h0 && idx < 4'h4 |->
    beat_col[2] == first[2])
    else $error("chop left its nibble");
  a_seq_order: assert property (beat_valid && !bt && !wr && idx != 4'h0 |->
    beat_col == {first[2] ^ idx[2], first[1:0] + idx[1:0]}) else $error("bad sequential order");
  a_ilv_order: assert property (beat_valid && bt && !wr && idx != 4'h0 |->
    beat_col == (first ^ idx[2:0])) else $error("bad interleaved order");
  a_wr_order: assert property (beat_valid && wr |-> beat_col[1:0] == idx[1:0])
    else $error("write beat out of order");
  a_mrs_guard: assert property (cmd == mrz_pkg::CMD_MRS |-> !beat_valid ##1 s_quiet)
    else $error("command too soon after mode load");
endmodule : mrz_asserts

// File: tb.sv
// Self-checking bench joining the controller end and the device end.
`timescale 1ns/1ps
module tb;
  logic        clock, rst_b, req_valid, pd_entry, req_ready, dll_locked, dll_reset_pulse;
  logic        dll_running, fixed_eight_beat_burst, burst_active, burst_is_write;
  logic [1:0]  req_kind;
  logic [18:0] req_data, mode_reg_zero;
  logic [3:0]  read_latency_cycles;
  int          errors = 0, num_checks = 0, pulses = 0;
  mrz_if link();
  mrz_ctrl #(.DLL_LOCK(16)) u_mrz_ctrl (.clock(clock), .rst_b(rst_b), .link(link),
    .req_valid(req_valid), .req_kind(req_kind), .req_data(req_data),
    .req_ready(req_ready), .dll_locked(dll_locked));
  mrz_device u_mrz_device (.clock(clock), .rst_b(rst_b), .link(link), .pd_entry(pd_entry),
    .mode_reg_zero(mode_reg_zero), .read_latency_cycles(read_latency_cycles),
    .dll_reset_pulse(dll_reset_pulse), .dll_running(dll_running),
    .fixed_eight_beat_burst(fixed_eight_beat_burst), .burst_active(burst_active),
    .burst_is_write(burst_is_write));
  mrz_asserts u_chk (.clock(clock), .rst_b(rst_b), .cmd(link.cmd), .bank(link.bank),
    .addr(link.addr), .dq_oe(link.dq_oe), .beat_col(link.beat_col),
    .beat_valid(link.beat_valid));
  // Clock at 200 MHz and a count of DLL reset pulses.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (dll_reset_pulse === 1'b1) pulses <= pulses + 1;
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds a request until the controller takes it.
  task automatic issue(input logic [1:0] kind, input logic [18:0] data);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_kind  <= kind;
    req_data  <= data;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    chk(19'(n < 300), 19'h1);
    @(posedge clock);
    req_valid <= 1'b0;
  endtask : issue
  // Loads the mode register and compares the captured image.
  task automatic t_load(input logic [18:0] val);
    int p;
    logic [18:0] e;
    p = pulses;
    e = val & ~mrz_pkg::RSVD_MASK & 19'h0FEFF;
    if (e[11:9] == 3'h0 || e[11:9] == 3'h7) e[11:9] = mrz_pkg::WR_12;
    issue(2'h0, val);
    repeat (3) @(negedge clock);
    chk(mode_reg_zero, e);
    chk(19'(pulses - p), 19'(val[8]));
  endtask : t_load
  // Runs one burst and compares every beat slot.
  task automatic t_burst(input logic wr, input logic [15:0] a, input logic bt, input logic l8);
    int n;
    logic [2:0] e;
    n = 0;
    issue(wr ? 2'h2 : 2'h1, {3'h0, a});
    while (link.beat_valid !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk(19'(n < 40), 19'h1);
    for (int i = 0; i < 8; i++) begin
      e = wr ? (l8 ? i[2:0] : {a[2], i[1:0]}) :
          bt ? a[2:0] ^ i[2:0] : {a[2] ^ i[2], a[1:0] + i[1:0]};
      chk(19'(link.beat_valid), 19'(l8 || i < 4));
      if (l8 || i < 4) chk(19'(link.beat_col), 19'(e));
      chk(19'(link.dq_oe), 19'(!wr && (l8 || i < 4)));
      chk(19'(burst_active), 19'h1);
      @(negedge clock);
    end
    chk(19'(fixed_eight_beat_burst), 19'(l8));
    chk(19'(burst_is_write), 19'(wr));
  endtask : t_burst
  // Enters and leaves precharge power-down.
  task automatic t_pd(input logic pd);
    @(posedge clock);
    pd_entry <= 1'b1;
    repeat (6) @(negedge clock);
    chk(19'(dll_running), 19'(pd));
    @(posedge clock);
    pd_entry <= 1'b0;
    repeat (6) @(negedge clock);
  endtask : t_pd
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Main sequence of scenarios.
  initial begin
    rst_b     = 1'b0;
    req_valid = 1'b0;
    req_kind  = 2'h0;
    req_data  = 19'h00000;
    pd_entry  = 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk(mode_reg_zero, mrz_pkg::RESET_VAL);
    t_load(19'h7E1FF);
    chk(19'(dll_locked), 19'h0);
    t_load(19'h00220);
    chk(19'(read_latency_cycles), 19'h6);
    t_burst(1'b0, 16'h0001, 1'b0, 1'b1);
    chk(19'(dll_locked), 19'h1);
    t_burst(1'b1, 16'h0005, 1'b0, 1'b1);
    t_load(19'h0022A);
    t_burst(1'b0, 16'h1003, 1'b1, 1'b0);
    t_burst(1'b1, 16'h0005, 1'b1, 1'b0);
    t_load(19'h00229);
    t_burst(1'b0, 16'h1005, 1'b1, 1'b1);
    t_burst(1'b0, 16'h0006, 1'b1, 1'b0);
    t_load(19'h01221);
    t_burst(1'b0, 16'h0007, 1'b0, 1'b0);
    t_burst(1'b0, 16'h1006, 1'b0, 1'b1);
    t_pd(1'b1);
    t_load(19'h00221);
    t_pd(1'b0);
    complete_run();
  end
  // Watchdog against a hang.
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule : tb
